/* File: rtl/cpcv_map.vh */
// Register map, field positions and reset values of the codec control registers
`ifndef CPCV_MAP_VH
`define CPCV_MAP_VH
// Byte address is four times a register number (2, 4, 0x10, 0x20), not the two-bit store index
`define CPCV_OFF_FORMAT 12'h008
`define CPCV_OFF_PWRCLK 12'h010
`define CPCV_OFF_VOLUME 12'h040
`define CPCV_OFF_STATUS 12'h080
`define CPCV_IDX_FORMAT 2'h0
`define CPCV_IDX_PWRCLK 2'h1
`define CPCV_IDX_VOLUME 2'h2
`define CPCV_FMT_I2S 3'h0
`define CPCV_FMT_LSB16 3'h1
`define CPCV_FMT_LSB18 3'h2
`define CPCV_FMT_LSB20 3'h3
`define CPCV_FMT_LSB24 3'h4
`define CPCV_FMT_MSB 3'h5
`define CPCV_FMT_DEFAULT 3'h0
`define CPCV_FMT_RESET 16'h0000
`define CPCV_FMT_MASK 16'h0007
`define CPCV_PWR_RESET 16'h8705
`define CPCV_PWR_MASK 16'h87c5
`define CPCV_VOL_RESET 16'h0000
`define CPCV_BIT_DAC_PON 15
`define CPCV_BIT_ADCL_PON 10
`define CPCV_BIT_ADCR_PON 9
`define CPCV_BIT_BIAS_PON 8
`define CPCV_BIT_DACCLK_EN 7
`define CPCV_BIT_DACCLK_AUTO 6
`define CPCV_BIT_DEC_EN 2
`define CPCV_BIT_INT_EN 0
`define CPCV_ATTEN_MAX_CODE 8'hd0
`define CPCV_ATTEN_STEP2_END 8'hec
`define CPCV_ATTEN_STEP3_END 8'hf4
`define CPCV_ATTEN_STEP4_END 8'hf8
`define CPCV_ATTEN_Q_STEP2_END 10'h108
`define CPCV_ATTEN_Q_STEP3_END 10'h120
`define CPCV_ATTEN_MUTE 10'h3ff
`endif

/* File: rtl/cpcv_reg_store.v */
// Three-word register store with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "cpcv_map.vh"
module cpcv_reg_store (
	input wire ref_clk,
	input wire rst_n,
	input wire wrEn,
	input wire [1:0] wrIdx,
	input wire [15:0] wrData,
	input wire [1:0] rdIdx,
	output reg [15:0] rdData,
	output wire [15:0] word0,
	output wire [15:0] word1,
	output wire [15:0] word2
);
	reg [15:0] mem0;
	reg [15:0] mem1;
	reg [15:0] mem2;
	assign word0 = mem0;
	assign word1 = mem1;
	assign word2 = mem2;
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			mem0 <= `CPCV_FMT_RESET;
			mem1 <= `CPCV_PWR_RESET;
			mem2 <= `CPCV_VOL_RESET;
			rdData <= 16'h0000;
		end
		else
		begin
			// Reserved bits are masked so they always read zero
			if (wrEn && wrIdx == `CPCV_IDX_FORMAT)
				mem0 <= wrData & `CPCV_FMT_MASK;
			if (wrEn && wrIdx == `CPCV_IDX_PWRCLK)
				mem1 <= wrData & `CPCV_PWR_MASK;
			if (wrEn && wrIdx == `CPCV_IDX_VOLUME)
				mem2 <= wrData;
			case (rdIdx)
				`CPCV_IDX_FORMAT: rdData <= mem0;
				`CPCV_IDX_PWRCLK: rdData <= mem1;
				`CPCV_IDX_VOLUME: rdData <= mem2;
				default: rdData <= 16'h0000;
			endcase
		end
	end
endmodule // cpcv_reg_store
`default_nettype wire

/* File: rtl/cpcv_regs.v */
// APB register bank for codec format, power, clock gating and master volume
`timescale 1ns/10ps
`default_nettype none
`include "cpcv_map.vh"
// What this block does
// (RL1) Decode format codes to I2S, LSB, MSB
// (RL2) Unused format codes select the default format
// (RL3) Bit 15 powers DAC on when set
// (RL4) DAC power bit drives DAC directly
// (RL5) Bias bit zero unpowers both ADCs
// (RL6) Per-channel ADC bits powered under bias
// (RL7) Bit 7 enables the DAC clock
// (RL8) Bit 6 enables automatic DAC clock gating
// (RL9) Auto on and PLL unlocked: mute, stop
// (RL10) Bit 2 runs decimator and ADC clock
// (RL11) Bit 0 runs the interpolator clock; the DAC clock follows bit 7 unless auto stop holds it
// (RL12) Left code high byte, right low byte
// (RL13) Attenuation 0 to -78 dB plus mute
// (RL14) Codes to 0xd0 give quarter-dB steps
module cpcv_regs (
	input wire ref_clk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire pslverr,
	output wire [31:0] prdata,
	input wire fractionalPllLocked,
	output reg [2:0] inputFormatSel,
	output reg dacPowerOn,
	output reg adcLeftPowered,
	output reg adcRightPowered,
	output reg dacClockRun,
	output reg decimatorClockRun,
	output reg interpolatorClockRun,
	output reg interpolatorMute,
	output reg [9:0] leftAttenQuarterDb,
	output reg [9:0] rightAttenQuarterDb
);
	// Attenuation in quarter-dB units; all ones means infinite (mute)
	// Above the quarter-dB range the step widens per segment, so each has its own slope
	function [9:0] attenOf;
		input [7:0] code;
		reg [7:0] delta;
		begin
			delta = 8'h00;
			if (code <= `CPCV_ATTEN_MAX_CODE)
				attenOf = {2'b00, code}; // (RL14)
			else if (code <= `CPCV_ATTEN_STEP2_END)
			begin
				delta = code - `CPCV_ATTEN_MAX_CODE;
				attenOf = {2'b00, `CPCV_ATTEN_MAX_CODE} + {1'b0, delta, 1'b0}; // (RL13)
			end
			else if (code <= `CPCV_ATTEN_STEP3_END)
			begin
				delta = code - `CPCV_ATTEN_STEP2_END;
				attenOf = `CPCV_ATTEN_Q_STEP2_END + {2'b00, delta} + {1'b0, delta, 1'b0}; // (RL13)
			end
			else if (code <= `CPCV_ATTEN_STEP4_END)
			begin
				delta = code - `CPCV_ATTEN_STEP3_END;
				attenOf = `CPCV_ATTEN_Q_STEP3_END + {1'b0, delta, 1'b0} + {delta, 2'b00}; // (RL13)
			end
			else
				attenOf = `CPCV_ATTEN_MUTE; // (RL13)
		end
	endfunction

	// The bias supply gates both channels, so a channel bit alone powers nothing
	function adcPowerOf;
		input bias;
		input channel;
		begin
			adcPowerOf = bias && channel; // (RL5) (RL6)
		end
	endfunction

	function [1:0] indexOf;
		input [11:0] addr;
		begin
			case (addr)
				`CPCV_OFF_FORMAT: indexOf = `CPCV_IDX_FORMAT;
				`CPCV_OFF_PWRCLK: indexOf = `CPCV_IDX_PWRCLK;
				`CPCV_OFF_VOLUME: indexOf = `CPCV_IDX_VOLUME;
				default: indexOf = 2'h3;
			endcase
		end
	endfunction
	wire [15:0] fmtWord;
	wire [15:0] pwrWord;
	wire [15:0] volWord;
	wire [15:0] storeRd;
	wire [1:0] accIdx;
	wire isStatus;
	wire known;
	wire access;
	reg phaseTwo;
	reg statusRd;
	reg errRd;
	reg pllSeen;

	assign accIdx = indexOf(paddr);
	assign isStatus = (paddr == `CPCV_OFF_STATUS);
	assign known = (accIdx != 2'h3) || (isStatus && !pwrite);
	assign access = psel && penable;
	// Read data comes from a register, so each transfer waits one extra cycle
	assign pready = phaseTwo;
	assign pslverr = phaseTwo && errRd;
	assign prdata = statusRd ? {31'h00000000, pllSeen} :
		(errRd ? 32'h00000000 : {16'h0000, storeRd});

	// Ready rises for one cycle after the first access cycle, giving one wait state
	always @(posedge ref_clk)
	begin
		if (!rst_n)
			phaseTwo <= 1'b0;
		else
			phaseTwo <= access && !phaseTwo;
	end

	// Read source and error are captured with the address of the first access cycle
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			statusRd <= 1'b0;
			errRd <= 1'b0;
		end
		else
		begin
			statusRd <= isStatus;
			errRd <= !known;
		end
	end

	// Lock status is sampled so read data leave from a flip-flop
	always @(posedge ref_clk)
	begin
		if (!rst_n)
			pllSeen <= 1'b0;
		else
			pllSeen <= fractionalPllLocked;
	end

	cpcv_reg_store store (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wrEn(access && !phaseTwo && pwrite && known),
		.wrIdx(accIdx),
		.wrData(pwdata[15:0]),
		.rdIdx(accIdx),
		.rdData(storeRd),
		.word0(fmtWord),
		.word1(pwrWord),
		.word2(volWord)
	);
	wire autoStop;
	assign autoStop = pwrWord[`CPCV_BIT_DACCLK_AUTO] && !fractionalPllLocked; // (RL8)

	// Unused format codes fall back so the input never sees an undefined setting
	always @(posedge ref_clk)
	begin
		if (!rst_n)
			inputFormatSel <= `CPCV_FMT_DEFAULT;
		else
		begin
			case (fmtWord[2:0])
				`CPCV_FMT_I2S, `CPCV_FMT_LSB16, `CPCV_FMT_LSB18, `CPCV_FMT_LSB20,
				`CPCV_FMT_LSB24, `CPCV_FMT_MSB: inputFormatSel <= fmtWord[2:0]; // (RL1)
				default: inputFormatSel <= `CPCV_FMT_DEFAULT; // (RL2)
			endcase
		end
	end

	// Not combined with mute, so the DAC stays powered through a lock loss
	always @(posedge ref_clk)
	begin
		if (!rst_n)
			dacPowerOn <= 1'b0;
		else
			dacPowerOn <= pwrWord[`CPCV_BIT_DAC_PON]; // (RL3) (RL4)
	end

	always @(posedge ref_clk)
	begin
		if (!rst_n)
			adcLeftPowered <= 1'b0;
		else
			adcLeftPowered <= adcPowerOf(pwrWord[`CPCV_BIT_BIAS_PON],
				pwrWord[`CPCV_BIT_ADCL_PON]); // (RL5) (RL6)
	end

	always @(posedge ref_clk)
	begin
		if (!rst_n)
			adcRightPowered <= 1'b0;
		else
			adcRightPowered <= adcPowerOf(pwrWord[`CPCV_BIT_BIAS_PON],
				pwrWord[`CPCV_BIT_ADCR_PON]); // (RL5) (RL6)
	end

	// Auto stop follows the live lock input, so a relock restarts the clock by itself
	always @(posedge ref_clk)
	begin
		if (!rst_n)
			dacClockRun <= 1'b0;
		else
			dacClockRun <= pwrWord[`CPCV_BIT_DACCLK_EN] && !autoStop; // (RL7) (RL9)
	end

	always @(posedge ref_clk)
	begin
		if (!rst_n)
			interpolatorMute <= 1'b0;
		else
			interpolatorMute <= autoStop; // (RL9)
	end

	always @(posedge ref_clk)
	begin
		if (!rst_n)
			decimatorClockRun <= 1'b0;
		else
			decimatorClockRun <= pwrWord[`CPCV_BIT_DEC_EN]; // (RL10)
	end

	always @(posedge ref_clk)
	begin
		if (!rst_n)
			interpolatorClockRun <= 1'b0;
		else
			interpolatorClockRun <= pwrWord[`CPCV_BIT_INT_EN]; // (RL11)
	end

	// Each channel decodes its own byte; the two never share a code
	always @(posedge ref_clk)
	begin
		if (!rst_n)
			leftAttenQuarterDb <= 10'h000;
		else
			leftAttenQuarterDb <= attenOf(volWord[15:8]); // (RL12)
	end

	always @(posedge ref_clk)
	begin
		if (!rst_n)
			rightAttenQuarterDb <= 10'h000;
		else
			rightAttenQuarterDb <= attenOf(volWord[7:0]); // (RL12)
	end

endmodule // cpcv_regs
`default_nettype wire

/* File: bench/cpcv_regs_sva.sv */
// Checker for the codec control register bank
`timescale 1ns/10ps
`default_nettype none
module cpcv_regs_sva (
	input wire logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic fractionalPllLocked, dacPowerOn, adcLeftPowered, adcRightPowered,
	input wire logic dacClockRun, decimatorClockRun, interpolatorClockRun, interpolatorMute,
	input wire logic [2:0] inputFormatSel,
	input wire logic [9:0] leftAttenQuarterDb, rightAttenQuarterDb
);
	// Completed writes per register; outputs follow one clock later
	wire done = psel & penable & pready & pwrite & ~pslverr;
	wire w2 = done & (paddr == 12'h008);
	wire w4 = done & (paddr == 12'h010);
	wire w10 = done & (paddr == 12'h040);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_fmt; w2 |=> inputFormatSel == ($past(pwdata[2:0]) > 3'h5 ? 3'h0 : $past(pwdata[2:0])); endproperty
	a_fmt: assert property (p_fmt) else $error("format decode wrong");
	property p_dac; w4 |=> dacPowerOn == $past(pwdata[15]); endproperty
	a_dac: assert property (p_dac) else $error("dac power wrong");
	property p_adcl; w4 |=> adcLeftPowered == $past(pwdata[10] & pwdata[8]); endproperty
	a_adcl: assert property (p_adcl) else $error("left adc power wrong");
	property p_adcr; w4 |=> adcRightPowered == $past(pwdata[9] & pwdata[8]); endproperty
	a_adcr: assert property (p_adcr) else $error("right adc power wrong");
	property p_dec; w4 |=> decimatorClockRun == $past(pwdata[2]); endproperty
	a_dec: assert property (p_dec) else $error("decimator clock wrong");
	property p_int; w4 |=> interpolatorClockRun == $past(pwdata[0]); endproperty
	a_int: assert property (p_int) else $error("interpolator clock wrong");
	property p_mute; interpolatorMute |-> !dacClockRun && !$past(fractionalPllLocked); endproperty
	a_mute: assert property (p_mute) else $error("mute without clock stop");
	property p_vol; w10 && pwdata[15:8] <= 8'hd0 && pwdata[7:0] <= 8'hd0 |=>
		leftAttenQuarterDb == {2'h0, $past(pwdata[15:8])} && rightAttenQuarterDb == {2'h0, $past(pwdata[7:0])}; endproperty
	a_vol: assert property (p_vol) else $error("attenuation wrong");
endmodule // cpcv_regs_sva
`default_nettype wire

/* File: bench/tb.sv */
// Testbench for the codec control register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, fractionalPllLocked = 1;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	logic err;
	wire pready, pslverr, dacPowerOn, adcLeftPowered, adcRightPowered, dacClockRun;
	wire decimatorClockRun, interpolatorClockRun, interpolatorMute;
	wire [31:0] prdata;
	wire [2:0] inputFormatSel;
	wire [9:0] leftAttenQuarterDb, rightAttenQuarterDb;
	int miscompares = 0, num_checks = 0, cyc = 0;
	cpcv_regs i_cpcv_regs (.*);
	always #25 ref_clk = ~ref_clk;
	task automatic chk(input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Called just after a rising edge; the idle cycle at the end avoids a double drive
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge ref_clk);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			miscompares++;
			results();
		end
	end
	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1;
		@(posedge ref_clk);
		xfer(0, 12'h010, 0);
		chk(rd, 32'h8705);
		for (int f = 0; f < 8; f++)
		begin
			xfer(1, 12'h008, f);
			chk(inputFormatSel, f > 5 ? 0 : f);
		end
		xfer(1, 12'h010, 32'h0600);
		chk({dacPowerOn, adcLeftPowered, adcRightPowered, decimatorClockRun, interpolatorClockRun}, 0);
		xfer(1, 12'h010, 32'h8505);
		chk({dacPowerOn, adcLeftPowered, adcRightPowered, decimatorClockRun, interpolatorClockRun}, 5'h1b);
		xfer(1, 12'h010, 32'h8300);
		chk({dacPowerOn, adcLeftPowered, adcRightPowered, decimatorClockRun, interpolatorClockRun}, 5'h14);
		xfer(1, 12'h010, 32'h00c0);
		chk({dacClockRun, interpolatorMute}, 2'h2);
		fractionalPllLocked <= 0;
		repeat (2) @(posedge ref_clk);
		chk({dacClockRun, interpolatorMute}, 2'h1);
		xfer(1, 12'h010, 32'h0080);
		chk({dacClockRun, interpolatorMute}, 2'h2);
		xfer(1, 12'h010, 32'h0000);
		chk(dacClockRun, 0);
		xfer(1, 12'h040, 32'hd001);
		chk({leftAttenQuarterDb, rightAttenQuarterDb}, {10'hd0, 10'h1});
		xfer(1, 12'h040, 32'hf0f8);
		chk({leftAttenQuarterDb, rightAttenQuarterDb}, {10'h114, 10'h138});
		xfer(1, 12'h040, 32'hecfc);
		chk({leftAttenQuarterDb, rightAttenQuarterDb}, {10'h108, 10'h3ff});
		xfer(1, 12'h040, 32'hd001);
		xfer(0, 12'h040, 0);
		chk(rd, 32'hd001);
		xfer(0, 12'h00c, 0);
		chk({31'h0, err}, 1);
		chk(rd, 0);
		results();
	end
endmodule // tb
bind cpcv_regs cpcv_regs_sva i_cpcv_regs_sva (.*);
`default_nettype wire
